// file: design/ptu_apb.sv
// APB register slave: control, correction values and status
// One wait state on every access; unmapped offsets answer with pslverr
`timescale 1ns/100ps
`default_nettype none
module ptu_apb
  import ptu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] stat_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic en_o,
  output logic [1:0] role_o,
  output logic [31:0] tx_corr_o,
  output logic [31:0] rx_corr_o
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic en;
    logic [1:0] role;
    logic [31:0] txc;
    logic [31:0] rxc;
  } ptu_apb_st_t;
  ptu_apb_st_t st_r;
  ptu_apb_st_t st_nxt;
  logic hit;
  logic [31:0] rd;
  logic [31:0] wv;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    hit = 1'b1;
    rd = 32'h00000000;
    case (paddr_i)
      REG_CTRL: rd = {29'h00000000, st_r.role, st_r.en};
      REG_TXC: rd = st_r.txc;
      REG_RXC: rd = st_r.rxc;
      REG_STAT: rd = stat_i;
      default: hit = 1'b0;
    endcase
    wv = merge(rd, pwdata_i, pstrb_i);
    // Answer registered: data and error stand with pready
    if (psel_i && penable_i && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !hit;
      st_nxt.prdata = pwrite_i ? 32'h00000000 : rd;
    end
    if (psel_i && penable_i && st_r.pready && pwrite_i) begin
      case (paddr_i)
        REG_CTRL: begin
          st_nxt.en = wv[CTRL_EN_BIT];
          st_nxt.role = wv[CTRL_ROLE_LSB +: 2];
        end
        REG_TXC: st_nxt.txc = wv;
        REG_RXC: st_nxt.rxc = wv;
        default: st_nxt.en = st_r.en;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.en <= CTRL_EN_RST;
      st_r.role <= ROLE_OC;
      st_r.txc <= CORR_RST;
      st_r.rxc <= CORR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign en_o = st_r.en;
  assign role_o = st_r.role;
  assign tx_corr_o = st_r.txc;
  assign rx_corr_o = st_r.rxc;
endmodule
`default_nettype wire

// file: design/ptu_crc32.sv
// Byte-serial Ethernet CRC-32 accumulator
// Fed by the emitting side of the transmit datapath, one byte per enable
`timescale 1ns/100ps
`default_nettype none
module ptu_crc32
  import ptu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [7:0] byte_i,
  output logic [31:0] crc_o
);
  typedef struct packed {
    logic [31:0] crc;
  } ptu_crc_st_t;
  ptu_crc_st_t st_r;
  ptu_crc_st_t st_nxt;
  logic [31:0] seed;

  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] x;
    x = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  always_comb begin
    st_nxt = st_r;
    seed = clr_i ? CRC_INIT : st_r.crc;
    if (en_i) begin
      st_nxt.crc = crc_upd(seed, byte_i);
    end else begin
      st_nxt.crc = seed;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign crc_o = st_r.crc;
endmodule
`default_nettype wire

// file: design/ptu_pkg.sv
// PTP timestamp unit: shared constants, encodings and types
// Assumes one 20 MHz clock for client, line, time-of-day and APB sides
// Behaviour
// - One-step: client gives stamp offset and insert request; stamp written there
// - Residence and correction requests add egress minus ingress time into correction
// - UDP over IPv6: trailing spare bytes rewritten so UDP checksum stays valid
// - Any modified frame gets a fresh CRC-32 replacing its trailing checksum
// - Two-step: egress request returns that frame's egress stamp with its fingerprint
// - One-step and two-step requests coexist, each frame by its own requests
// - Ordinary/boundary roles touch Sync or Pdelay_Resp only when two-step flag clear
// - Transparent roles never insert stamps; correction only with residence request
// - Every received frame carries a stamp shown on its first beat
// - Stamps come from a continuous external 96-bit time-of-day input
// - Software sets separate transmit and receive stamp correction values
// - PTP found in untagged, VLAN, stacked VLAN and MPLS-labelled frames
// - Each VLAN tag moves later fields by four octets, a stacked pair by eight
package ptu_pkg;
  // ==========================================
  // Datapath
  localparam int DLY = 10;
  localparam int FP_W = 8;
  localparam logic [15:0] TS_BYTES = 16'h000a;
  localparam logic [15:0] FCS_LEN = 16'h0004;
  localparam logic [15:0] EXT_POS = 16'h0006;
  localparam logic [31:0] NS_PER_SEC = 32'h3b9aca00;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  // ==========================================
  // Frame parsing
  localparam logic [15:0] ET_POS = 16'h000c;
  localparam logic [15:0] ET_VLAN = 16'h8100;
  localparam logic [15:0] ET_QINQ = 16'h88a8;
  localparam logic [15:0] ET_MPLS = 16'h8847;
  localparam logic [15:0] ET_PTP = 16'h88f7;
  localparam logic [15:0] ET_IPV4 = 16'h0800;
  localparam logic [15:0] ET_IPV6 = 16'h86dd;
  localparam logic [15:0] TAG_LEN = 16'h0004;
  localparam logic [15:0] BOS_POS = 16'h0002;
  localparam logic [15:0] OFF_L2 = 16'h0002;
  localparam logic [15:0] OFF_V4 = 16'h001e;
  localparam logic [15:0] OFF_V6 = 16'h0032;
  localparam logic [15:0] OFF_MV4 = 16'h001c;
  localparam logic [15:0] OFF_MV6 = 16'h0030;
  localparam logic [3:0] IPV4_NIB = 4'h4;
  localparam logic [3:0] IPV6_NIB = 4'h6;
  localparam logic [15:0] FLAG_POS = 16'h0006;
  localparam int TWO_STEP_BIT = 1;
  localparam logic [15:0] CF_POS = 16'h0008;
  localparam logic [15:0] CF_END = 16'h000f;
  localparam logic [3:0] MSG_SYNC = 4'h0;
  localparam logic [3:0] MSG_DREQ = 4'h1;
  localparam logic [3:0] MSG_PDRESP = 4'h3;
  localparam logic [3:0] MSG_NONE = 4'hf;
  // ==========================================
  // Clock roles and registers
  localparam logic [1:0] ROLE_OC = 2'h0;
  localparam logic [1:0] ROLE_E2E = 2'h2;
  localparam logic [1:0] ROLE_P2P = 2'h3;
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXC = 8'h04;
  localparam logic [7:0] REG_RXC = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ROLE_LSB = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [31:0] CORR_RST = 32'h00000000;
  // ==========================================
  // Types
  typedef enum logic [1:0] {P_ETH, P_MPLS, P_MPLSP, P_DONE} ptu_pst_t;
  typedef enum logic [1:0] {ENC_NONE, ENC_L2, ENC_V4, ENC_V6} ptu_enc_t;
endpackage

// file: design/ptu_top.sv
// PTP timestamp unit: transmit one-step/two-step stamping, receive stamping
// Client and line streams are byte wide on mclk_i; time-of-day runs on mclk_i too
`timescale 1ns/100ps
`default_nettype none
module ptu_top
  import ptu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [95:0] tod_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_first_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  input wire logic ts_ins_req_i,
  input wire logic [15:0] ts_offset_i,
  input wire logic res_update_req_i,
  input wire logic cf_update_req_i,
  input wire logic [95:0] ingress_ts_i,
  input wire logic egress_req_valid_i,
  input wire logic [FP_W-1:0] fingerprint_i,
  output logic [7:0] line_data_o,
  output logic line_valid_o,
  output logic line_first_o,
  output logic line_last_o,
  output logic egress_ts_valid_o,
  output logic [95:0] egress_ts_o,
  output logic [FP_W-1:0] egress_fp_o,
  input wire logic [7:0] rx_line_data_i,
  input wire logic rx_line_valid_i,
  input wire logic rx_line_first_i,
  input wire logic rx_line_last_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_frame_first_beat_o,
  output logic rx_last_o,
  output logic [95:0] rx_ts_o
);
  // ==========================================
  // State
  typedef struct packed {
    logic [DLY-1:0][7:0] dd;
    logic [DLY-1:0] dv;
    logic [DLY-1:0] dl;
    logic [15:0] in_pos;
    logic [15:0] out_pos;
    logic [15:0] len;
    logic len_ok;
    logic [7:0] prev;
    ptu_pst_t pst;
    ptu_enc_t enc;
    logic [15:0] base;
    logic [15:0] ptp;
    logic [3:0] msg;
    logic two_step;
    logic ins_req;
    logic [15:0] ts_off;
    logic res_req;
    logic cf_req;
    logic eg_req;
    logic [FP_W-1:0] fp;
    logic [47:0] ing;
    logic [95:0] ets;
    logic [63:0] cf_old;
    logic [15:0] acc;
    logic [7:0] ext_lo;
    logic ready;
    logic drain;
    logic [7:0] ln_data;
    logic ln_valid;
    logic ln_first;
    logic ln_last;
    logic ret_valid;
    logic [95:0] ret_ts;
    logic [FP_W-1:0] ret_fp;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_first;
    logic rx_last;
    logic [95:0] rx_ts;
    logic [15:0] mod_cnt;
  } ptu_st_t;
  ptu_st_t st_r;
  ptu_st_t st_nxt;

  logic en;
  logic [1:0] role;
  logic [31:0] txc;
  logic [31:0] rxc;
  logic [31:0] crc_q;
  logic crc_clr;
  logic crc_en;
  logic [7:0] crc_byte;
  logic acc_beat;
  logic shift;
  logic [15:0] pos;
  logic [15:0] w;
  logic [15:0] op;
  logic [7:0] ob;
  logic [7:0] nb;
  logic [15:0] k;
  logic [15:0] r;
  logic [15:0] j;
  logic [79:0] tsw;
  logic [63:0] cfw;
  logic [31:0] fw;
  logic [15:0] word;
  logic [95:0] ets_now;
  logic [48:0] d;
  logic [63:0] cf_new;
  logic tc;
  logic is_ev;
  logic cf_role;
  logic ins_ok;
  logic cf_ok;
  logic mod;

  // ==========================================
  // Helpers
  function automatic logic [95:0] ts_adj(input logic [95:0] t, input logic [31:0] c);
    logic [32:0] ns;
    logic [47:0] sec;
    ns = {1'b0, t[47:16]} + {1'b0, c};
    sec = t[95:48];
    if (ns >= {1'b0, NS_PER_SEC}) begin
      ns = ns - {1'b0, NS_PER_SEC};
      sec = sec + 48'h000000000001;
    end
    return {sec, ns[31:0], t[15:0]};
  endfunction

  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  ptu_apb u_apb (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .stat_i({st_r.mod_cnt, 15'h0000, st_r.drain}),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .en_o(en),
    .role_o(role),
    .tx_corr_o(txc),
    .rx_corr_o(rxc)
  );

  ptu_crc32 u_crc (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .clr_i(crc_clr),
    .en_i(crc_en),
    .byte_i(crc_byte),
    .crc_o(crc_q)
  );

  // ==========================================
  // Per-frame decisions
  // adjusted time-of-day stamp
  assign ets_now = ts_adj(tod_i, txc);
  // residence in 2^-16 ns, wraps at one second
  assign d = ({1'b0, st_r.ets[47:0]} - {1'b0, st_r.ing}) +
             (({1'b0, st_r.ets[47:16]} < {1'b0, st_r.ing[47:16]}) ? {1'b0, NS_PER_SEC, 16'h0000} : 49'h0);
  assign cf_new = st_r.cf_old + {16'h0000, d[47:0]};
  assign tc = (role == ROLE_E2E) || (role == ROLE_P2P);
  assign is_ev = en && (st_r.enc != ENC_NONE);
  // correction only for the role's event set
  assign cf_role = (!tc && st_r.msg == MSG_PDRESP && !st_r.two_step) ||
                   (role == ROLE_E2E && st_r.msg <= MSG_PDRESP) ||
                   (role == ROLE_P2P && (st_r.msg == MSG_SYNC || st_r.msg == MSG_DREQ || st_r.msg == MSG_PDRESP));
  assign ins_ok = is_ev && st_r.ins_req && !tc && st_r.msg == MSG_SYNC && !st_r.two_step;
  assign cf_ok = is_ev && st_r.cf_req && st_r.res_req && cf_role;
  assign mod = ins_ok || cf_ok;

  // ==========================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    acc_beat = tx_valid_i && st_r.ready;
    // Line side never stalls; input gaps just hold the delay line
    shift = acc_beat || st_r.drain;
    pos = tx_first_i ? 16'h0000 : st_r.in_pos;
    w = {st_r.prev, tx_data_i};
    op = st_r.out_pos;
    ob = st_r.dd[DLY-1];
    nb = ob;
    k = op - st_r.ts_off;
    r = op - st_r.ptp;
    j = op - (st_r.len - FCS_LEN);
    tsw = st_r.ets[95:16] << {k[3:0], 3'b000};
    cfw = cf_new << {r[2:0], 3'b000};
    fw = ~crc_q >> {j[1:0], 3'b000};
    word = oc_add({ob, st_r.dd[DLY-2]}, st_r.acc);
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_byte = 8'h00;
    st_nxt.ln_valid = 1'b0;
    st_nxt.ln_first = 1'b0;
    st_nxt.ln_last = 1'b0;
    st_nxt.ret_valid = 1'b0;

    // Input side: request capture and header walk
    if (acc_beat) begin
      st_nxt.in_pos = pos + 16'h0001;
      st_nxt.prev = tx_data_i;
      // requests belong to the frame they start
      if (tx_first_i) begin
        st_nxt.pst = P_ETH;
        st_nxt.enc = ENC_NONE;
        st_nxt.base = ET_POS;
        st_nxt.len_ok = 1'b0;
        st_nxt.msg = MSG_NONE;
        st_nxt.two_step = 1'b0;
        st_nxt.acc = 16'h0000;
        st_nxt.ins_req = ts_ins_req_i;
        st_nxt.ts_off = ts_offset_i;
        st_nxt.res_req = res_update_req_i;
        st_nxt.cf_req = cf_update_req_i;
        st_nxt.eg_req = egress_req_valid_i;
        st_nxt.fp = fingerprint_i;
        st_nxt.ing = ingress_ts_i[47:0];
      end
      // header walk through tags and labels
      case (st_nxt.pst)
        P_ETH: begin
          if (pos == st_nxt.base + 16'h0001) begin
            // each tag shifts the type field
            if (w == ET_VLAN || w == ET_QINQ) begin
              st_nxt.base = st_nxt.base + TAG_LEN;
            end else if (w == ET_MPLS) begin
              st_nxt.pst = P_MPLS;
              st_nxt.base = st_nxt.base + OFF_L2;
            end else begin
              st_nxt.pst = P_DONE;
              if (w == ET_PTP) begin
                st_nxt.enc = ENC_L2;
                st_nxt.ptp = st_nxt.base + OFF_L2;
              end else if (w == ET_IPV4) begin
                st_nxt.enc = ENC_V4;
                st_nxt.ptp = st_nxt.base + OFF_V4;
              end else if (w == ET_IPV6) begin
                st_nxt.enc = ENC_V6;
                st_nxt.ptp = st_nxt.base + OFF_V6;
              end
            end
          end
        end
        P_MPLS: begin
          // Any depth of labels until bottom of stack
          if (pos == st_nxt.base + BOS_POS) begin
            if (tx_data_i[0]) begin
              st_nxt.pst = P_MPLSP;
            end
            st_nxt.base = st_nxt.base + TAG_LEN;
          end
        end
        P_MPLSP: begin
          if (pos == st_nxt.base) begin
            st_nxt.pst = P_DONE;
            if (tx_data_i[7:4] == IPV4_NIB) begin
              st_nxt.enc = ENC_V4;
              st_nxt.ptp = st_nxt.base + OFF_MV4;
            end else if (tx_data_i[7:4] == IPV6_NIB) begin
              st_nxt.enc = ENC_V6;
              st_nxt.ptp = st_nxt.base + OFF_MV6;
            end
          end
        end
        default: begin
          if (st_nxt.enc != ENC_NONE) begin
            if (pos == st_nxt.ptp) begin
              st_nxt.msg = tx_data_i[3:0];
            end
            if (pos == st_nxt.ptp + FLAG_POS) begin
              st_nxt.two_step = tx_data_i[TWO_STEP_BIT];
            end
            if (pos >= st_nxt.ptp + CF_POS && pos <= st_nxt.ptp + CF_END) begin
              st_nxt.cf_old = {st_nxt.cf_old[55:0], tx_data_i};
            end
          end
        end
      endcase
      // One frame in flight: refuse input until the tail leaves
      if (tx_last_i) begin
        st_nxt.len = pos + 16'h0001;
        st_nxt.len_ok = 1'b1;
        st_nxt.ready = 1'b0;
        st_nxt.drain = 1'b1;
      end
    end

    // Delay line lets the tail and correction field be known before use
    if (shift) begin
      st_nxt.dd = {st_r.dd[DLY-2:0], tx_data_i};
      st_nxt.dv = {st_r.dv[DLY-2:0], acc_beat};
      st_nxt.dl = {st_r.dl[DLY-2:0], acc_beat && tx_last_i};
    end

    // Output side: edit, checksum and emit
    if (shift && st_r.dv[DLY-1]) begin
      if (op == 16'h0000) begin
        st_nxt.ets = ets_now;
        crc_clr = 1'b1;
        st_nxt.ret_valid = st_r.eg_req;
        st_nxt.ret_ts = ets_now;
        st_nxt.ret_fp = st_r.fp;
      end
      if (ins_ok && op >= st_r.ts_off && k < TS_BYTES) begin
        nb = tsw[79:72];
      end
      if (cf_ok && r >= CF_POS && r <= CF_END) begin
        nb = cfw[63:56];
      end
      if (nb != ob) begin
        st_nxt.acc = oc_add(oc_add(st_r.acc, op[0] ? {8'h00, ob} : {ob, 8'h00}),
                            op[0] ? {8'hff, ~nb} : {~nb, 8'hff});
      end
      if (st_r.enc == ENC_V6 && mod && st_r.len_ok) begin
        if (op == st_r.len - EXT_POS) begin
          nb = word[15:8];
          st_nxt.ext_lo = word[7:0];
        end else if (op == st_r.len - EXT_POS + 16'h0001) begin
          nb = st_r.ext_lo;
        end
      end
      if (!st_r.len_ok || op + FCS_LEN < st_r.len) begin
        crc_en = 1'b1;
        crc_byte = nb;
      end else if (mod) begin
        nb = fw[7:0];
      end
      st_nxt.ln_data = nb;
      st_nxt.ln_valid = 1'b1;
      st_nxt.ln_first = op == 16'h0000;
      st_nxt.ln_last = st_r.dl[DLY-1];
      st_nxt.out_pos = op + 16'h0001;
      if (st_r.dl[DLY-1]) begin
        st_nxt.out_pos = 16'h0000;
        st_nxt.drain = 1'b0;
        st_nxt.ready = 1'b1;
        if (mod) begin
          st_nxt.mod_cnt = st_r.mod_cnt + 16'h0001;
        end
      end
    end

    st_nxt.rx_data = rx_line_data_i;
    st_nxt.rx_valid = rx_line_valid_i;
    st_nxt.rx_first = rx_line_valid_i && rx_line_first_i;
    st_nxt.rx_last = rx_line_valid_i && rx_line_last_i;
    if (rx_line_valid_i && rx_line_first_i) begin
      st_nxt.rx_ts = ts_adj(tod_i, rxc);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.ready <= 1'b1;
      st_r.msg <= MSG_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign tx_ready_o = st_r.ready;
  assign line_data_o = st_r.ln_data;
  assign line_valid_o = st_r.ln_valid;
  assign line_first_o = st_r.ln_first;
  assign line_last_o = st_r.ln_last;
  assign egress_ts_valid_o = st_r.ret_valid;
  assign egress_ts_o = st_r.ret_ts;
  assign egress_fp_o = st_r.ret_fp;
  assign rx_data_o = st_r.rx_data;
  assign rx_valid_o = st_r.rx_valid;
  assign rx_frame_first_beat_o = st_r.rx_first;
  assign rx_last_o = st_r.rx_last;
  assign rx_ts_o = st_r.rx_ts;
endmodule
`default_nettype wire

// file: tb/ptu_line_model.sv
// Far-end line model: sends 20-byte receive frames on request
// Bench clock; released data toggles between the inverse of the last byte and that byte
`timescale 1ns/100ps
`default_nettype none
module ptu_line_model (
  input wire logic mclk_i,
  input wire logic go_i,
  output logic [7:0] data_o,
  output logic valid_o,
  output logic first_o,
  output logic last_o
);
  int cnt = 0;
  initial {data_o, valid_o, first_o, last_o} = '0;
  always @(posedge mclk_i) begin
    valid_o <= cnt != 0;
    first_o <= cnt == 20;
    last_o <= cnt == 1;
    data_o <= cnt != 0 ? 8'(cnt) ^ 8'h5a : ~data_o;
    cnt <= cnt != 0 ? cnt - 1 : (go_i ? 20 : 0);
  end
endmodule
`default_nettype wire

// file: tb/ptu_props.sv
// Checker: stream, stamp and APB timing at the ptu_top ports
// Bound into ptu_top by the bench; one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module ptu_props (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic tx_valid_i,
  input wire logic tx_first_i,
  input wire logic tx_last_i,
  input wire logic tx_ready_o,
  input wire logic egress_req_valid_i,
  input wire logic line_first_o,
  input wire logic line_last_o,
  input wire logic egress_ts_valid_o,
  input wire logic rx_line_first_i,
  input wire logic rx_frame_first_beat_o,
  input wire logic [95:0] rx_ts_o
);
  // ====
  // Fixed 11-beat latency; valid for gapless input only
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_sof; tx_valid_i && tx_first_i && tx_ready_o; endsequence
  sequence s_eof; tx_valid_i && tx_last_i && tx_ready_o; endsequence
  property p_sof; s_sof |-> ##11 line_first_o; endproperty
  a_sof: assert property (p_sof) else $error("late start");
  property p_egr; s_sof ##0 egress_req_valid_i |-> ##11 egress_ts_valid_o; endproperty
  a_egr: assert property (p_egr) else $error("no stamp");
  property p_one; egress_ts_valid_o |-> line_first_o; endproperty
  a_one: assert property (p_one) else $error("stamp skew");
  property p_eof; s_eof |-> ##11 line_last_o; endproperty
  a_eof: assert property (p_eof) else $error("late end");
  property p_hold; s_eof |=> !tx_ready_o [*8]; endproperty
  a_hold: assert property (p_hold) else $error("early ready");
  property p_rxs; rx_line_first_i |=> rx_frame_first_beat_o; endproperty
  a_rxs: assert property (p_rxs) else $error("rx start lost");
  property p_rxt; !rx_frame_first_beat_o |-> $stable(rx_ts_o); endproperty
  a_rxt: assert property (p_rxt) else $error("rx stamp moved");
  property p_apb; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_apb: assert property (p_apb) else $error("apb late");
endmodule
`default_nettype wire

// file: tb/ptu_top_bench.sv
// Bench: APB setup, PTP frames on tx, stamped rx frames
// Needs ptu_pkg, the design, ptu_props and ptu_line_model
`timescale 1ns/100ps
`default_nettype none
module ptu_top_bench;
  import ptu_pkg::*;
  logic mclk_i = '0, rst_n_i = '0, psel_i = '0, penable_i = '0, pwrite_i = '0, tx_valid_i = '0;
  logic tx_first_i = '0, tx_last_i = '0, ts_ins_req_i = '0, res_update_req_i = '0, cf_update_req_i = '0;
  logic egress_req_valid_i = '0, pready_o, pslverr_o, tx_ready_o, line_valid_o, line_first_o, rx_go = '0;
  logic line_last_o, egress_ts_valid_o, rx_line_valid_i, rx_line_first_i, rx_line_last_i, e;
  logic rx_valid_o, rx_frame_first_beat_o, rx_last_o;
  logic [7:0] paddr_i = '0, tx_data_i = '0, line_data_o, rx_line_data_i, rx_data_o;
  logic [FP_W-1:0] fingerprint_i = '0, egress_fp_o;
  logic [31:0] pwdata_i = '0, prdata_o, rxc = '0, r;
  logic [3:0] pstrb_i = 4'hf;
  logic [15:0] ts_offset_i = '0;
  logic [95:0] tod_i = 96'habcd << 48, ingress_ts_i = '0, egress_ts_o, rx_ts_o, exp_rx = '0;
  logic [7:0] fr [64];
  logic [7:0] ob [64];
  logic [23:0] c;
  logic [63:0] cf, cq;
  // Nibbles: message, flags, vlan/ipv4/role, insert, correction, modified
  logic [23:0] cs [12] = '{24'h000101, 24'h020100, 24'h800100, 24'h002100, 24'h002011, 24'h000000,
    24'h303011, 24'h103011, 24'h203010, 24'h300011, 24'h008101, 24'h107011};
  int fails = 0, samples_checked = 0, seed = 89063, n = 0, ne = 0, nx = 0, k, v, p;
  ptu_top ptu_top_inst (.*);
  ptu_line_model ptu_line_model_inst (.mclk_i, .go_i(rx_go), .data_o(rx_line_data_i),
    .valid_o(rx_line_valid_i), .first_o(rx_line_first_i), .last_o(rx_line_last_i));
  always #25 mclk_i = ~mclk_i;
  // ====
  // Capture and rx stamp check
  always @(posedge mclk_i) begin
    tod_i[47:16] <= tod_i[47:16] + 32'h32;
    if (line_valid_o === 1'b1) begin
      n = line_first_o ? 1 : n + 1;
      ob[n - 1] = line_data_o;
    end
    if (egress_ts_valid_o === 1'b1) ne++;
    if (rx_line_first_i) exp_rx <= {tod_i[95:48], tod_i[47:16] + rxc, tod_i[15:0]};
    if (rx_frame_first_beat_o === 1'b1) chk(rx_ts_o, exp_rx);
  end
  task automatic chk(input logic [95:0] g, input logic [95:0] x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait on pready or tx ready
  task automatic await(input bit ap);
    for (k = 0; k < 40 && (ap ? pready_o : tx_ready_o) !== 1'b1; k++) @(posedge mclk_i);
    if ((ap ? pready_o : tx_ready_o) !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    await(1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic send();
    for (int i = 0; i < 64; i++) fr[i] = 8'($random(seed));
    v = c[15] ? 4 : 0;
    p = c[14] ? 42 + v : 14 + v;
    fr[12] = 8'h81;
    fr[13] = 8'h00;
    fr[12 + v] = c[14] ? 8'h08 : 8'h88;
    fr[13 + v] = c[14] ? 8'h00 : 8'hf7;
    if (c[14]) {fr[40 + v], fr[41 + v]} = 16'h0000;
    fr[p] = {4'h0, c[23:20]};
    fr[p + 6] = {4'h0, c[19:16]};
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk_i);
      tx_valid_i <= 1'b1;
      tx_first_i <= i == 0;
      tx_last_i <= i == 63;
      tx_data_i <= fr[i];
      ts_ins_req_i <= c[8];
      ts_offset_i <= 16'(48 + v);
      res_update_req_i <= c[4];
      cf_update_req_i <= c[4];
      egress_req_valid_i <= fr[1][0];
      fingerprint_i <= fr[0];
      ingress_ts_i <= tod_i;
    end
    @(posedge mclk_i);
    tx_valid_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    await(1'b0);
    @(posedge mclk_i);
  endtask
  function automatic logic [31:0] crc();
    logic [31:0] q;
    q = CRC_INIT;
    for (int i = 0; i < 60; i++) begin
      q[7:0] = q[7:0] ^ ob[i];
      for (int b = 0; b < 8; b++) q = q[0] ? (q >> 1) ^ CRC_POLY : q >> 1;
    end
    return ~q;
  endfunction
  // ====
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, REG_CTRL, '0);
    chk(r, 96'h1);
    rxc = $random(seed) & 32'h0000ffff;
    apb(1'b1, REG_RXC, rxc);
    apb(1'b1, REG_TXC, rxc);
    apb(1'b0, REG_RXC, '0);
    chk(r, rxc);
    apb(1'b0, 8'h10, '0);
    chk(e, 1'b1);
    repeat (3) begin
      rx_go <= 1'b1;
      @(posedge mclk_i);
      rx_go <= 1'b0;
      repeat (24) @(posedge mclk_i);
    end
    for (int j = 0; j < 12; j++) begin
      c = cs[j];
      apb(1'b1, REG_CTRL, {29'h0, c[13:12], 1'b1});
      send();
      nx = nx + fr[1][0];
      chk(ne, nx);
      if (fr[1][0]) chk(egress_fp_o, fr[0]);
      if (fr[1][0]) chk(egress_ts_o[95:48], 48'habcd);
      if (c[0]) chk({ob[63], ob[62], ob[61], ob[60]}, crc());
      else for (int i = 0; i < 64; i++) chk(ob[i], fr[i]);
      // Residence: 11 cycles of 50 ns plus the tx correction
      if (c[4] && c[0]) begin
        for (int i = 0; i < 8; i++) begin
          cf = {cf[55:0], fr[p + 8 + i]};
          cq = {cq[55:0], ob[p + 8 + i]};
        end
        chk(cq, cf + ((64'd550 + rxc) << 16));
      end
      if (c[0] && c[8]) for (int i = 0; i < 6; i++) chk(ob[48 + v + i], tod_i[95 - 8 * i -: 8]);
    end
    end_of_test();
  end
endmodule
bind ptu_top ptu_props ptu_props_inst (.*);
`default_nettype wire
